// ### include/sub_ops_pkg.sv
/*
  constants shared by the subtract execution unit and its testbench.
  assumes one 100 MHz clock domain and a 32-bit avalon-mm register port.
*/
`default_nettype none
package sub_ops_pkg;
  // opcode layout
  localparam logic [7:0] LIT_SUB_UPPER = 8'h08;
  localparam logic [5:0] FILE_SUB_UPPER = 6'h17;
  localparam int DEST_BIT = 9;
  localparam int ACCESS_BIT = 8;
  // access bank: low half of the 8-bit field maps to bank 0, high half to bank F
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  // register byte offsets
  localparam logic [7:0] OPCODE_OFFSET = 8'h00;
  localparam logic [7:0] ACC_OFFSET = 8'h04;
  localparam logic [7:0] BANK_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0C;
  // status field positions
  localparam int CARRY_POS = 0;
  localparam int DIGIT_POS = 1;
  localparam int ZERO_POS = 2;
  localparam int OVF_POS = 3;
  localparam int NEG_POS = 4;
  localparam int BUSY_POS = 7;
  localparam int ILLEGAL_POS = 8;
  // reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam logic [15:0] OPCODE_RESET = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC = 2'b10
  } exec_state_type;
endpackage
`default_nettype wire

// ### rtl/sub_flags_core.sv
/*
  8-bit two's-complement subtractor, minuend minus subtrahend, with flags.
  assumes purely combinational use inside the execution unit.
*/
`timescale 1ns/1ps
`default_nettype none
module sub_flags_core (
  // operands
  input wire logic [7:0] minuend,
  input wire logic [7:0] subtrahend,
  // result and flags
  output logic [7:0] difference,
  output logic carry_flag,
  output logic digit_carry_flag,
  output logic zero_flag,
  output logic overflow_flag,
  output logic negative_flag
);
  wire [8:0] full_sum;
  wire [4:0] low_sum;
  // subtraction as add of inverted operand plus one; carry out means no borrow
  assign full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
  assign low_sum = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
  assign difference = full_sum[7:0];
  assign carry_flag = full_sum[8];
  assign digit_carry_flag = low_sum[4];
  assign zero_flag = (full_sum[7:0] == 8'h00);
  assign negative_flag = full_sum[7];
  assign overflow_flag = (minuend[7] != subtrahend[7]) && (full_sum[7] != minuend[7]);
endmodule
`default_nettype wire

// ### rtl/sub_exec_unit.sv
/*
  execution unit for the literal-subtract and file-subtract instructions,
  with accumulator, bank select and status flags, reached over avalon-mm.
  assumes a synchronous data memory on the same clock: read data is valid
  one cycle after the read strobe.
*/
// The register addresses and the Avalon-MM register port were decided locally.
// Contract
// [RULE1] upper byte 08h is literal subtract
// [RULE2] literal minus accumulator into accumulator
// [RULE3] file register minus accumulator
// [RULE4] destination bit 0 writes accumulator
// [RULE5] access bit 1 uses bank select
// [RULE6] destination bit 1 writes file register
// [RULE7] access bit 0 uses access bank
// [RULE8] both update carry zero negative overflow digit
`timescale 1ns/1ps
`default_nettype none
module sub_exec_unit
  import sub_ops_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // avalon-mm slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // data memory port
  output logic [11:0] dmem_addr,
  output logic dmem_re,
  output logic dmem_we,
  output logic [7:0] dmem_wdata,
  input wire logic [7:0] dmem_rdata
);
  exec_state_type state;
  exec_state_type next_state;
  logic [15:0] opcode;
  logic [7:0] working_accumulator;
  logic [3:0] bank_select_register;
  logic [4:0] flags;
  logic illegal;
  logic ack;
  logic [7:0] operand;

  function automatic logic is_lit_sub(input logic [15:0] op);
    return op[15:8] == LIT_SUB_UPPER;
  endfunction

  function automatic logic is_file_sub(input logic [15:0] op);
    return op[15:10] == FILE_SUB_UPPER;
  endfunction

  function automatic logic [11:0] form_addr(input logic [15:0] op, input logic [3:0] bank);
    logic [11:0] result;
    result = {ACCESS_LOW_BANK, op[7:0]};
    if (op[ACCESS_BIT]) begin
      result = {bank, op[7:0]};
    end else if (op[7]) begin
      result = {ACCESS_HIGH_BANK, op[7:0]};
    end
    return result;
  endfunction

  wire busy = (state != ST_IDLE);
  wire access = read | write;
  // writes wait while an instruction runs so software never races the datapath
  wire stall = write & busy;
  wire take = access & ~ack & ~stall;
  wire wr_take = take & write;
  wire hit_opcode = (address == OPCODE_OFFSET);
  wire hit_acc = (address == ACC_OFFSET);
  wire hit_bank = (address == BANK_OFFSET);
  wire hit_status = (address == STATUS_OFFSET);
  wire start = wr_take & hit_opcode;
  wire [15:0] new_opcode = writedata[15:0];
  // [RULE1] literal subtract decode
  wire start_lit = start & is_lit_sub(new_opcode);
  wire start_file = start & is_file_sub(new_opcode);
  wire start_bad = start & ~is_lit_sub(new_opcode) & ~is_file_sub(new_opcode);
  wire dest_file = opcode[DEST_BIT];
  wire in_exec = (state == ST_EXEC);
  wire exec_lit = in_exec & is_lit_sub(opcode);
  wire exec_file = in_exec & is_file_sub(opcode);

  wire [7:0] diff;
  wire c_flag;
  wire dc_flag;
  wire z_flag;
  wire ov_flag;
  wire n_flag;
  // [RULE2] literal is minuend
  // [RULE3] file register is minuend
  wire [7:0] minuend = exec_file ? dmem_rdata : operand;

  sub_flags_core core (
    .minuend(minuend),
    .subtrahend(working_accumulator),
    .difference(diff),
    .carry_flag(c_flag),
    .digit_carry_flag(dc_flag),
    .zero_flag(z_flag),
    .overflow_flag(ov_flag),
    .negative_flag(n_flag)
  );

  wire [4:0] result_flags = {n_flag, ov_flag, z_flag, dc_flag, c_flag};
  wire [31:0] status_word = {23'h000000, illegal, busy, 2'b00, flags};
  wire [31:0] read_mux = hit_opcode ? {16'h0000, opcode} :
                         hit_acc ? {24'h000000, working_accumulator} :
                         hit_bank ? {28'h0000000, bank_select_register} :
                         hit_status ? status_word : 32'h00000000;

  assign waitrequest = access & ~ack;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_lit) begin
          next_state = ST_EXEC;
        end else if (start_file) begin
          next_state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        next_state = ST_EXEC;
      end
      ST_EXEC: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      ack <= 1'b0;
      readdata <= 32'h00000000;
    end else begin
      state <= next_state;
      ack <= take;
      if (take & read) begin
        readdata <= read_mux;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      opcode <= OPCODE_RESET;
      operand <= 8'h00;
    end else if (start) begin
      opcode <= new_opcode;
      operand <= new_opcode[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      working_accumulator <= ACC_RESET;
    end else if (exec_lit | (exec_file & ~dest_file)) begin
      // [RULE4] accumulator destination
      working_accumulator <= diff;
    end else if (wr_take & hit_acc) begin
      working_accumulator <= writedata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bank_select_register <= BANK_RESET;
    end else if (wr_take & hit_bank) begin
      bank_select_register <= writedata[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flags <= FLAGS_RESET;
    end else if (exec_lit | exec_file) begin
      // [RULE8] flags from result
      flags <= result_flags;
    end else if (wr_take & hit_status) begin
      flags <= writedata[NEG_POS:CARRY_POS];
    end
  end

  // illegal opcode is sticky; writing 1 clears it, a new illegal start wins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      illegal <= 1'b0;
    end else if (start_bad) begin
      illegal <= 1'b1;
    end else if (wr_take & hit_status & writedata[ILLEGAL_POS]) begin
      illegal <= 1'b0;
    end
  end

  // data memory strobes are registered, so the write lands one cycle after exec
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dmem_addr <= 12'h000;
      dmem_re <= 1'b0;
      dmem_we <= 1'b0;
      dmem_wdata <= 8'h00;
    end else begin
      dmem_re <= start_file;
      // [RULE6] file register destination
      dmem_we <= exec_file & dest_file;
      if (start_file) begin
        // [RULE5] banked address
        // [RULE7] access bank address
        dmem_addr <= form_addr(new_opcode, bank_select_register);
      end
      if (exec_file & dest_file) begin
        dmem_wdata <= diff;
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/dmem_model.sv
/* data memory partner for the subtract unit.
   assumes the unit's strobes come from the same clock. */
`timescale 1ns/1ps
`default_nettype none
module dmem_model (
  // memory port
  input wire logic clk,
  input wire logic [11:0] dmem_addr,
  input wire logic dmem_re,
  input wire logic dmem_we,
  input wire logic [7:0] dmem_wdata,
  output logic [7:0] dmem_rdata
);
  logic [7:0] mem [4096];
  // a wrong address reads the fill pattern
  initial for (int i = 0; i < 4096; i++) mem[i] = 8'hA5;
  initial dmem_rdata = 8'h00;
  // stale data toggles so nothing reads valid by chance
  always @(posedge clk) begin
    if (dmem_we) mem[dmem_addr] <= dmem_wdata;
    dmem_rdata <= dmem_re ? mem[dmem_addr] : ~dmem_rdata;
  end
endmodule
`default_nettype wire

// ### verification/sub_exec_checker.sv
/* port checker for sub_exec_unit.
   assumes the bind below and one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module sub_exec_checker (
  // watched ports
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] address,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic waitrequest,
  input wire logic [11:0] dmem_addr,
  input wire logic dmem_re,
  input wire logic dmem_we
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire op_w = write && !waitrequest && address == 8'h00;
  wire lit_w = op_w && writedata[15:8] == 8'h08;
  wire file_w = op_w && writedata[15:10] == 6'h17;
  lit_no_mem_a: assert property (lit_w |-> !dmem_re ##1 !dmem_re)
    else $error("literal op read memory");
  access_bank_a: assert property (file_w && !writedata[8] |-> dmem_re &&
    dmem_addr == {{4{writedata[7]}}, writedata[7:0]}) else $error("access bank address wrong");
  bank_field_a: assert property (file_w && writedata[8] |-> dmem_re &&
    dmem_addr[7:0] == writedata[7:0]) else $error("banked address wrong");
  acc_dest_a: assert property (file_w && !writedata[9] |=> !dmem_we [*4])
    else $error("register written for acc dest");
  file_dest_a: assert property (file_w && writedata[9] |-> ##2 dmem_we)
    else $error("register write missing");
  we_pulse_a: assert property (dmem_we |=> !dmem_we)
    else $error("write strobe too long");
  same_reg_a: assert property (dmem_we |-> $stable(dmem_addr) && $past(dmem_re, 2))
    else $error("written register not the one read");
  re_pulse_a: assert property (dmem_re |=> !dmem_re)
    else $error("read strobe too long");
endmodule
`default_nettype wire
bind sub_exec_unit sub_exec_checker u_sub_exec_checker (.clk, .rst_b, .address, .write,
  .writedata, .waitrequest, .dmem_addr, .dmem_re, .dmem_we);

// ### verification/testbench.sv
/* self-checking bench for sub_exec_unit over avalon-mm.
   assumes dmem_model as data memory and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench;
  import sub_ops_pkg::*;
  logic clk = 0, rst_b = 0, read = 0, write = 0, waitrequest, dmem_re, dmem_we;
  logic [7:0] address = 8'h00, dmem_wdata, dmem_rdata;
  logic [31:0] writedata = 32'h0, readdata, rd;
  logic [11:0] dmem_addr, ma;
  int n_fail = 0, checks_done = 0, cyc = 0;
  sub_exec_unit u_sub_exec_unit (.clk, .rst_b, .address, .read, .write, .writedata, .readdata,
    .waitrequest, .dmem_addr, .dmem_re, .dmem_we, .dmem_wdata, .dmem_rdata);
  dmem_model u_dmem_model (.clk, .dmem_addr, .dmem_re, .dmem_we, .dmem_wdata, .dmem_rdata);
  initial forever #5 clk = ~clk;
  task automatic end_sim();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ceiling sits well above the few hundred cycles the tests need, so only a hang reaches it
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    address <= a;
    writedata <= wd;
    write <= wr;
    read <= !wr;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [31:0] flags(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] r;
    r = a - b;
    return {27'h0, r[7], (a[7] != b[7]) && (r[7] != a[7]), r == 8'h00, a[3:0] >= b[3:0], a >= b};
  endfunction
  task automatic res(input logic [7:0] acc, input logic [31:0] st);
    repeat (5) @(posedge clk);
    bus(ACC_OFFSET, 1'b0, 32'h0);
    `CHK(rd, {24'h0, acc})
    bus(STATUS_OFFSET, 1'b0, 32'h0);
    `CHK(rd, st)
  endtask
  task automatic lit(input logic [7:0] w, input logic [7:0] k);
    bus(ACC_OFFSET, 1'b1, {24'h0, w});
    bus(OPCODE_OFFSET, 1'b1, {16'h0, LIT_SUB_UPPER, k});
    res(k - w, flags(k, w));
  endtask
  task automatic fsub(input logic d, a, input logic [3:0] bank, input logic [7:0] f, v, w);
    ma = a ? {bank, f} : {f[7] ? ACCESS_HIGH_BANK : ACCESS_LOW_BANK, f};
    u_dmem_model.mem[ma] = v;
    bus(BANK_OFFSET, 1'b1, {28'h0, bank});
    bus(ACC_OFFSET, 1'b1, {24'h0, w});
    bus(OPCODE_OFFSET, 1'b1, {16'h0, FILE_SUB_UPPER, d, a, f});
    res(d ? w : v - w, flags(v, w));
    `CHK(u_dmem_model.mem[ma], d ? v - w : v)
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    bus(8'h10, 1'b0, 32'h0);
    `CHK(rd, 32'h0)
    lit(8'h01, 8'h02);
    lit(8'h02, 8'h02);
    lit(8'h03, 8'h02);
    // back to back: second write may be held off while busy
    bus(OPCODE_OFFSET, 1'b1, 32'h0810);
    bus(OPCODE_OFFSET, 1'b1, 32'h0805);
    bus(OPCODE_OFFSET, 1'b1, 32'h0908);
    res(8'hF4, flags(8'h05, 8'h11) | 32'h100);
    // illegal is sticky: clear it so later status reads carry only the flags
    bus(STATUS_OFFSET, 1'b1, 32'h100);
    fsub(1'b1, 1'b0, 4'h5, 8'h20, 8'h03, 8'h02);
    fsub(1'b0, 1'b0, 4'h5, 8'h90, 8'h02, 8'h02);
    fsub(1'b1, 1'b1, 4'h5, 8'h33, 8'h01, 8'h02);
    fsub(1'b0, 1'b1, 4'hA, 8'hC4, 8'h7F, 8'h80);
    // second opcode lands after the first file subtract ends: runs on its result, not dropped
    u_dmem_model.mem[12'h010] = 8'h08;
    bus(ACC_OFFSET, 1'b1, 32'h5);
    bus(OPCODE_OFFSET, 1'b1, {16'h0, FILE_SUB_UPPER, 2'b00, 8'h10});
    bus(OPCODE_OFFSET, 1'b1, {16'h0, FILE_SUB_UPPER, 2'b00, 8'h10});
    res(8'h05, flags(8'h08, 8'h03));
    `CHK(u_dmem_model.mem[12'h010], 8'h08)
    end_sim();
  end
endmodule
`default_nettype wire
